// ### common/dlic_pkg.sv
// Purpose: Constants and types shared by the dual-line interrupt controller.
// Assumes: 32 source bits, 8 external port B pins, APB byte addressing.
// Notes:   Bit positions are the single place the source map is defined.

package dlic_pkg;

	localparam int SRC_W  = 32;
	localparam int GPIO_N = 8;

	// ***************************************************************
	// Register byte offsets
	// ***************************************************************
	localparam logic [7:0] OFF_PENDING   = 8'h00;
	localparam logic [7:0] OFF_ROUTE     = 8'h04;
	localparam logic [7:0] OFF_ENABLE    = 8'h08;
	localparam logic [7:0] OFF_POLARITY  = 8'h0C;
	localparam logic [7:0] OFF_FAST_STAT = 8'h10;
	localparam logic [7:0] OFF_NORM_STAT = 8'h14;
	localparam logic [7:0] OFF_EVT_STAT  = 8'h18;
	localparam logic [7:0] OFF_EVT_MASK  = 8'h1C;

	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam logic [2:0]  EVT_RESET = 3'h0;

	// ***************************************************************
	// Source bit positions
	// ***************************************************************
	localparam int BIT_SIM_TIMER     = 0;
	localparam int BIT_GP_TIMER      = 1;
	localparam int BIT_DATA_BAUD     = 2;
	localparam int BIT_DEBUG_BAUD    = 3;
	localparam int BIT_RTC_ALARM     = 4;
	localparam int BIT_SIM           = 5;
	localparam int BIT_DMA_BASE      = 8;
	localparam int DMA_CHANNELS      = 5;
	localparam int BIT_DSP           = 13;
	localparam int BIT_DATA_TX       = 14;
	localparam int BIT_DATA_RX_START = 15;
	localparam int BIT_DATA_RX       = 16;
	localparam int BIT_DEBUG_TX      = 18;
	localparam int BIT_AUTOBAUD      = 19;
	localparam int BIT_DEBUG_RX      = 20;
	localparam int BIT_KEYPAD        = 24;

	// Port B pin n lands on GPIO_BIT[n]
	localparam int GPIO_BIT [GPIO_N] = '{17, 27, 7, 21, 23, 22, 28, 26};

	// Sticky event bit positions
	localparam int EVT_NEW_PEND = 0;
	localparam int EVT_FAST_UP  = 1;
	localparam int EVT_NORM_UP  = 2;
	localparam int EVT_W        = 3;

	function automatic logic [31:0] dlic_one(input int pos);
		dlic_one = 32'h00000001 << pos;
	endfunction

	function automatic logic [31:0] dlic_ext_mask();
		dlic_ext_mask = 32'h00000000;
		for (int i = 0; i < GPIO_N; i++) begin
			dlic_ext_mask = dlic_ext_mask | dlic_one(GPIO_BIT[i]);
		end
	endfunction

	function automatic logic [31:0] dlic_int_mask();
		dlic_int_mask = dlic_one(BIT_SIM_TIMER) | dlic_one(BIT_GP_TIMER)
			| dlic_one(BIT_DATA_BAUD) | dlic_one(BIT_DEBUG_BAUD)
			| dlic_one(BIT_RTC_ALARM) | dlic_one(BIT_SIM)
			| dlic_one(BIT_DSP) | dlic_one(BIT_DATA_TX)
			| dlic_one(BIT_DATA_RX_START) | dlic_one(BIT_DATA_RX)
			| dlic_one(BIT_DEBUG_TX) | dlic_one(BIT_AUTOBAUD)
			| dlic_one(BIT_DEBUG_RX) | dlic_one(BIT_KEYPAD);
		for (int i = 0; i < DMA_CHANNELS; i++) begin
			dlic_int_mask = dlic_int_mask | dlic_one(BIT_DMA_BASE + i);
		end
	endfunction

	localparam logic [31:0] EXT_SRC_MASK = dlic_ext_mask();
	localparam logic [31:0] INT_SRC_MASK = dlic_int_mask();
	localparam logic [31:0] RSVD_MASK    = ~(EXT_SRC_MASK | INT_SRC_MASK);

	typedef enum logic [3:0] {
		SEL_NONE, SEL_PENDING, SEL_ROUTE, SEL_ENABLE, SEL_POLARITY,
		SEL_FAST_STAT, SEL_NORM_STAT, SEL_EVT_STAT, SEL_EVT_MASK
	} dlic_sel_t;

	function automatic dlic_sel_t dlic_decode(input logic [7:0] addr);
		case (addr)
			OFF_PENDING:   dlic_decode = SEL_PENDING;
			OFF_ROUTE:     dlic_decode = SEL_ROUTE;
			OFF_ENABLE:    dlic_decode = SEL_ENABLE;
			OFF_POLARITY:  dlic_decode = SEL_POLARITY;
			OFF_FAST_STAT: dlic_decode = SEL_FAST_STAT;
			OFF_NORM_STAT: dlic_decode = SEL_NORM_STAT;
			OFF_EVT_STAT:  dlic_decode = SEL_EVT_STAT;
			OFF_EVT_MASK:  dlic_decode = SEL_EVT_MASK;
			default:       dlic_decode = SEL_NONE;
		endcase
	endfunction

endpackage

// ### src/dlic_edge_detect.sv
// Purpose: Edge detection for the port B external interrupt pins.
// Assumes: Pins are synchronous to clock.
// Notes:   Output is a one-cycle event vector in source bit layout.

`timescale 1ns/1ps
`default_nettype none

module dlic_edge_detect
	import dlic_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic [GPIO_N-1:0] gpioB,
	input  wire logic [SRC_W-1:0]  polarity,
	output logic      [SRC_W-1:0]  edgeEvent
);

	logic [SRC_W-1:0] mapped;
	logic [SRC_W-1:0] level;
	logic [SRC_W-1:0] prevLevel_ff;
	logic             armed_ff;

	// ***************************************************************
	// Pin placement
	// ***************************************************************
	// pins placed on bits
	always_comb begin
		mapped = REG_RESET;
		for (int i = 0; i < GPIO_N; i++) begin
			mapped[GPIO_BIT[i]] = gpioB[i];
		end
	end

	assign level = (mapped ^ polarity) & EXT_SRC_MASK;

	always_ff @(posedge clock) begin
		if (reset) begin
			prevLevel_ff <= REG_RESET;
			armed_ff     <= 1'b0;
		end else begin
			prevLevel_ff <= level;
			armed_ff     <= 1'b1;
		end
	end

	// First cycle after reset only learns the pin levels
	assign edgeEvent = armed_ff ? (level & ~prevLevel_ff) : REG_RESET;

endmodule // dlic_edge_detect

`default_nettype wire

// ### src/dlic_top.sv
// Purpose: Dual-line interrupt controller with APB register access.
// Assumes: Sources and pins are synchronous to clock; reset synchronous.
// Notes:   Every APB access takes one wait state.
// Operation
// - Every source latches into its pending bit regardless of enable.
// - A pending bit stays until source is gone and software clears it.
// - Enabled source goes to fast line when route bit is one.
// - Only enabled sources reach the core; disabled ones are suppressed. Here a disabled source's new pending event can still raise irqOut.
// - External source: polarity one means falling edge, zero rising.
// - Polarity bits of internal sources have no effect.
// - Fast status bit is pending and enabled and routed fast.
// - Normal status bit is pending and enabled and routed normal.
// - All registers but event status and event mask share the pending register bit layout.
// - Internal sources sit at fixed bits; bits 6, 25, 29-31 reserved.
// - DMA channels zero to four use bits eight to twelve.
// - Data port and debug port events use their fixed bits.
// - Port B pins are edge sources on their fixed bits.
// - All enabled sources combine into a fast or a normal request.
//
// Our own choices: the APB register port and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module dlic_top
	import dlic_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [SRC_W-1:0]  internalReq,
	input  wire logic [GPIO_N-1:0] gpioB,
	output logic                   fastIrq,
	output logic                   normalIrq,
	output logic                   irqOut
);

	// Elaboration check: only the low 5 to 8 address bits are decoded
	if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_check
		$error("dlic_top: ADDR_W must be 5 to 8");
	end

	logic [31:0]      pending_ff;
	logic [31:0]      route_ff;
	logic [31:0]      enable_ff;
	logic [31:0]      polarity_ff;
	logic [EVT_W-1:0] evtStat_ff;
	logic [EVT_W-1:0] evtMask_ff;
	logic [31:0]      prdata_ff;
	logic             pready_ff;
	logic             pslverr_ff;
	logic             fastIrq_ff;
	logic             normalIrq_ff;
	logic             irqOut_ff;

	logic [31:0]      nxt_pending;
	logic [EVT_W-1:0] nxt_evtStat;
	logic [31:0]      edgeEvent;
	logic [31:0]      intLive;
	logic [31:0]      setVec;
	logic [31:0]      fastStatus;
	logic [31:0]      normalStatus;
	logic [7:0]       addr8;
	dlic_sel_t        sel;
	logic             accessDone;
	logic             wrDone;
	logic             rdDone;
	logic             wrPend;
	logic             fastNext;
	logic             normalNext;

	// ***************************************************************
	// APB slave
	// ***************************************************************
	assign addr8      = 8'(paddr);
	assign sel        = dlic_decode(addr8);
	assign accessDone = psel && penable && pready_ff;
	assign wrDone     = accessDone && pwrite && !pslverr_ff;
	assign rdDone     = accessDone && !pwrite && !pslverr_ff;
	assign wrPend     = wrDone && sel == SEL_PENDING;

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else if (psel && penable && !pready_ff) begin
			pready_ff  <= 1'b1;
			pslverr_ff <= sel == SEL_NONE;
		end else begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			prdata_ff <= REG_RESET;
		end else if (psel && penable && !pready_ff && !pwrite) begin
			case (sel)
				SEL_PENDING:   prdata_ff <= pending_ff;
				SEL_ROUTE:     prdata_ff <= route_ff;
				SEL_ENABLE:    prdata_ff <= enable_ff;
				SEL_POLARITY:  prdata_ff <= polarity_ff;
				SEL_FAST_STAT: prdata_ff <= fastStatus;
				SEL_NORM_STAT: prdata_ff <= normalStatus;
				SEL_EVT_STAT:  prdata_ff <= 32'(evtStat_ff);
				SEL_EVT_MASK:  prdata_ff <= 32'(evtMask_ff);
				default:       prdata_ff <= REG_RESET;
			endcase
		end else begin
			prdata_ff <= REG_RESET;
		end
	end

	// ***************************************************************
	// Configuration registers
	// ***************************************************************
	// configuration cleared
	always_ff @(posedge clock) begin
		if (reset) begin
			route_ff <= REG_RESET;
		end else if (wrDone && sel == SEL_ROUTE) begin
			route_ff <= pwdata & ~RSVD_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			enable_ff <= REG_RESET;
		end else if (wrDone && sel == SEL_ENABLE) begin
			enable_ff <= pwdata & ~RSVD_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			polarity_ff <= REG_RESET;
		end else if (wrDone && sel == SEL_POLARITY) begin
			polarity_ff <= pwdata & EXT_SRC_MASK;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			evtMask_ff <= EVT_RESET;
		end else if (wrDone && sel == SEL_EVT_MASK) begin
			evtMask_ff <= pwdata[EVT_W-1:0];
		end
	end

	// ***************************************************************
	// Source capture
	// ***************************************************************
	dlic_edge_detect u_edge (
		.clock     (clock),
		.reset     (reset),
		.gpioB     (gpioB),
		.polarity  (polarity_ff),
		.edgeEvent (edgeEvent)
	);

	// internal source bits within internal mask
	assign intLive = internalReq & INT_SRC_MASK;
	assign setVec  = intLive | edgeEvent;

	// write-one clear loses to a live source
	always_comb begin
		nxt_pending = pending_ff;
		if (wrPend) begin
			nxt_pending = nxt_pending & ~pwdata;
		end
		nxt_pending = nxt_pending | setVec;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pending_ff <= REG_RESET;
		end else begin
			pending_ff <= nxt_pending;
		end
	end

	// ***************************************************************
	// Line routing
	// ***************************************************************
	// route bit picks the line
	assign fastStatus   = pending_ff & enable_ff & route_ff;
	assign normalStatus = pending_ff & enable_ff & ~route_ff;

	assign fastNext   = |fastStatus;
	assign normalNext = |normalStatus;

	always_ff @(posedge clock) begin
		if (reset) begin
			fastIrq_ff   <= 1'b0;
			normalIrq_ff <= 1'b0;
		end else begin
			fastIrq_ff   <= fastNext;
			normalIrq_ff <= normalNext;
		end
	end

	// ***************************************************************
	// Controller events
	// ***************************************************************
	// Read clears; a new event in that cycle survives the clear
	always_comb begin
		nxt_evtStat = evtStat_ff;
		if (rdDone && sel == SEL_EVT_STAT) begin
			nxt_evtStat = EVT_RESET;
		end
		if (|(setVec & ~pending_ff)) begin
			nxt_evtStat[EVT_NEW_PEND] = 1'b1;
		end
		if (fastNext && !fastIrq_ff) begin
			nxt_evtStat[EVT_FAST_UP] = 1'b1;
		end
		if (normalNext && !normalIrq_ff) begin
			nxt_evtStat[EVT_NORM_UP] = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			evtStat_ff <= EVT_RESET;
			irqOut_ff  <= 1'b0;
		end else begin
			evtStat_ff <= nxt_evtStat;
			irqOut_ff  <= |(nxt_evtStat & evtMask_ff);
		end
	end

	assign prdata    = prdata_ff;
	assign pready    = pready_ff;
	assign pslverr   = pslverr_ff;
	assign fastIrq   = fastIrq_ff;
	assign normalIrq = normalIrq_ff;
	assign irqOut    = irqOut_ff;

	// ***************************************************************
	// Assertions
	// ***************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	pend_capture_a: assert property (
		(|intLive) |=> ((pending_ff & $past(intLive)) == $past(intLive)))
		else $error("live source not captured in pending");

	pend_hold_a: assert property (
		!wrPend |=> ((pending_ff & $past(pending_ff)) == $past(pending_ff)))
		else $error("pending bit dropped without a clear");

	clear_blocked_a: assert property (
		(wrPend && pwdata[BIT_DSP] && intLive[BIT_DSP])
		|=> pending_ff[BIT_DSP])
		else $error("pending cleared while source still active");

	line_split_a: assert property (
		((fastStatus & normalStatus) == REG_RESET)
		&& ((fastStatus | normalStatus) == (pending_ff & enable_ff)))
		else $error("line split does not match enabled pending bits");

	disabled_quiet_a: assert property (
		(pending_ff != REG_RESET && enable_ff == REG_RESET)
		|=> !fastIrq && !normalIrq)
		else $error("request raised with no enabled source");

	fall_detect_a: assert property (
		($fell(gpioB[0]) && polarity_ff[GPIO_BIT[0]]
		&& $stable(polarity_ff) && $past(!reset))
		|=> pending_ff[GPIO_BIT[0]])
		else $error("falling edge missed with polarity one");

	rise_detect_a: assert property (
		($rose(gpioB[0]) && !polarity_ff[GPIO_BIT[0]]
		&& $stable(polarity_ff) && $past(!reset))
		|=> pending_ff[GPIO_BIT[0]])
		else $error("rising edge missed with polarity zero");

	pol_internal_a: assert property (
		(polarity_ff & ~EXT_SRC_MASK) == REG_RESET)
		else $error("polarity held on an internal bit");

	rsvd_zero_a: assert property (
		((pending_ff | enable_ff | route_ff) & RSVD_MASK) == REG_RESET)
		else $error("reserved bit set");

	line_or_a: assert property (
		##1 (fastIrq == $past(fastNext)) && (normalIrq == $past(normalNext)))
		else $error("request line not the OR of its status");

	reset_clear_a: assert property (
		$past(reset) |-> pending_ff == REG_RESET && enable_ff == REG_RESET
		&& route_ff == REG_RESET && !fastIrq && !normalIrq)
		else $error("state not cleared by reset");

	apb_wait_a: assert property (
		(psel && penable && !pready) |=> pready)
		else $error("APB access not answered in one wait state");

	fast_raise_c: cover property (!fastIrq ##1 fastIrq);
	normal_raise_c: cover property (!normalIrq ##1 normalIrq);
	gpio_capture_c: cover property (edgeEvent != REG_RESET);
	pend_clear_c: cover property (wrPend ##1 pending_ff == REG_RESET);

endmodule // dlic_top

`default_nettype wire

// ### bench/dlic_core_model.sv
// Purpose: Behavioural core side that takes the fast and normal requests.
// Assumes: Request lines are levels synchronous to clock.
// Notes:   Reports which request kind the core would service each cycle.

`timescale 1ns/1ps
`default_nettype none

module dlic_core_model (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic fastIrq,
	input  wire logic normalIrq,
	output logic      svcFast,
	output logic      svcNormal
);
	logic svcFast_ff;
	logic svcNormal_ff;

	always_ff @(posedge clock) begin
		if (reset) begin
			svcFast_ff   <= 1'b0;
			svcNormal_ff <= 1'b0;
		end else begin
			svcFast_ff   <= fastIrq;
			svcNormal_ff <= normalIrq & ~fastIrq & ~svcFast_ff;
		end
	end

	assign svcFast   = svcFast_ff;
	assign svcNormal = svcNormal_ff;
endmodule // dlic_core_model

`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench for the dual-line interrupt controller.
// Assumes: APB answers with pready; sources are driven on rising edges.
// Notes:   Sequences of register calls with worked-out expected values.

`timescale 1ns/1ps
`default_nettype none

module tb
	import dlic_pkg::*;
;
	logic              clock = 1'b0;
	logic              reset = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h00000000;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [SRC_W-1:0]  internalReq = 32'h00000000;
	logic [GPIO_N-1:0] gpioB = 8'h00;
	logic              fastIrq;
	logic              normalIrq;
	logic              irqOut;
	logic              svcFast;
	logic              svcNormal;
	int                errTotal = 0;
	int                checkCount = 0;
	logic [31:0]       rdat;
	logic              rerr;
	int intBits [19] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11, 12, 13, 14, 15,
		16, 18, 19, 20, 24};
	int pinBits [8] = '{17, 27, 7, 21, 23, 22, 28, 26};

	always #2 clock = ~clock;

	dlic_top dut (.clock(clock), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .internalReq(internalReq), .gpioB(gpioB),
		.fastIrq(fastIrq), .normalIrq(normalIrq), .irqOut(irqOut));

	dlic_core_model core (.clock(clock), .reset(reset), .fastIrq(fastIrq),
		.normalIrq(normalIrq), .svcFast(svcFast), .svcNormal(svcNormal));

	// ***************************************************************
	// Reporting
	// ***************************************************************
	task automatic endSim();
		$display("Checks %0d, mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkBit(input logic got, input logic exp);
		checkCount++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] t=%0t bit got %h exp %h", $time, got, exp);
		end
	endtask

	// ***************************************************************
	// APB master
	// ***************************************************************
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		@(posedge clock);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			errTotal++;
			endSim();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rdat, rerr);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000, rdat, rerr);
		chkWord(rdat, exp);
	endtask

	task automatic pulse(input int b);
		@(posedge clock);
		internalReq <= 32'h00000001 << b;
		@(posedge clock);
		internalReq <= 32'h00000000;
	endtask

	task automatic pins(input logic [7:0] v);
		@(posedge clock);
		gpioB <= v;
		repeat (2) @(posedge clock);
	endtask

	initial begin
		#200000;
		errTotal++;
		endSim();
	end

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		for (int o = 0; o < 32; o += 4) rdChk(8'(o), 32'h00000000);
		chkBit(fastIrq | normalIrq, 1'b0);
		apb(1'b0, 8'h20, 32'h00000000, rdat, rerr);
		chkBit(rerr, 1'b1);
		chkWord(rdat, 32'h00000000);
		wr32(OFF_FAST_STAT, 32'hFFFFFFFF);
		rdChk(OFF_FAST_STAT, 32'h00000000);
		wr32(OFF_ROUTE, 32'hFFFFFFFF);
		rdChk(OFF_ROUTE, 32'h1DFFFFBF);
		wr32(OFF_POLARITY, 32'hFFFFFFFF);
		rdChk(OFF_POLARITY, 32'h1CE20080);
		// Flipping polarity with pins low makes an edge on every pin bit
		rdChk(OFF_PENDING, 32'h1CE20080);
		wr32(OFF_PENDING, 32'hFFFFFFFF);
		wr32(OFF_ROUTE, 32'h00000000);
		// Internal sources latch with enable off and polarity set
		for (int i = 0; i < 19; i++) begin
			pulse(intBits[i]);
			rdChk(OFF_PENDING, 32'h00000001 << intBits[i]);
			chkBit(fastIrq | normalIrq, 1'b0);
			wr32(OFF_PENDING, 32'h00000001 << intBits[i]);
			rdChk(OFF_PENDING, 32'h00000000);
		end
		pulse(6);
		pulse(25);
		rdChk(OFF_PENDING, 32'h00000000);
		// Routing and line status
		wr32(OFF_ENABLE, 32'h00002002);
		wr32(OFF_ROUTE, 32'h00002000);
		pulse(13);
		rdChk(OFF_FAST_STAT, 32'h00002000);
		rdChk(OFF_NORM_STAT, 32'h00000000);
		chkBit(fastIrq, 1'b1);
		chkBit(normalIrq, 1'b0);
		pulse(1);
		rdChk(OFF_NORM_STAT, 32'h00000002);
		chkBit(normalIrq, 1'b1);
		chkBit(svcFast, 1'b1);
		chkBit(svcNormal, 1'b0);
		pulse(8);
		rdChk(OFF_PENDING, 32'h00002102);
		rdChk(OFF_FAST_STAT, 32'h00002000);
		wr32(OFF_PENDING, 32'h00002100);
		rdChk(OFF_FAST_STAT, 32'h00000000);
		chkBit(fastIrq, 1'b0);
		// Held source keeps pending through a clear
		@(posedge clock);
		internalReq <= 32'h00000002;
		wr32(OFF_PENDING, 32'h00000002);
		rdChk(OFF_PENDING, 32'h00000002);
		@(posedge clock);
		internalReq <= 32'h00000000;
		wr32(OFF_PENDING, 32'h00000002);
		rdChk(OFF_NORM_STAT, 32'h00000000);
		chkBit(normalIrq, 1'b0);
		wr32(OFF_ENABLE, 32'h00000000);
		// External pins, both polarities, enable off while changing
		for (int p = 0; p < 8; p++) begin
			wr32(OFF_POLARITY, 32'h00000000);
			wr32(OFF_PENDING, 32'hFFFFFFFF);
			pins(8'h01 << p);
			rdChk(OFF_PENDING, 32'h00000001 << pinBits[p]);
			wr32(OFF_PENDING, 32'hFFFFFFFF);
			pins(8'h00);
			rdChk(OFF_PENDING, 32'h00000000);
			wr32(OFF_POLARITY, 32'hFFFFFFFF);
			wr32(OFF_PENDING, 32'hFFFFFFFF);
			pins(8'h01 << p);
			rdChk(OFF_PENDING, 32'h00000000);
			pins(8'h00);
			rdChk(OFF_PENDING, 32'h00000001 << pinBits[p]);
			wr32(OFF_PENDING, 32'hFFFFFFFF);
		end
		// Event status, mask and read-clear
		// New pending, fast rise and normal rise were all seen above
		rdChk(OFF_EVT_STAT, 32'h00000007);
		rdChk(OFF_EVT_STAT, 32'h00000000);
		pulse(5);
		repeat (2) @(posedge clock);
		chkBit(irqOut, 1'b0);
		wr32(OFF_EVT_MASK, 32'h00000001);
		repeat (2) @(posedge clock);
		chkBit(irqOut, 1'b1);
		rdChk(OFF_EVT_STAT, 32'h00000001);
		repeat (2) @(posedge clock);
		chkBit(irqOut, 1'b0);
		rdChk(OFF_EVT_STAT, 32'h00000000);
		endSim();
	end
endmodule // tb

`default_nettype wire
